/* File: rsl_pkg.sv */
package rsl_pkg;

  // register bus geometry: one byte of data per 32-bit word
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int IDX_W = 8;
  localparam int PC_W  = 13;

  // program counter targets
  localparam logic [PC_W-1:0] PC_RESET  = 13'h000;
  localparam logic [PC_W-1:0] PC_VECTOR = 13'h004;
  localparam logic [PC_W-1:0] PC_STEP   = 13'h001;

  // core_status field positions
  localparam int ST_IRP = 7;
  localparam int ST_RP1 = 6;
  localparam int ST_RP0 = 5;
  localparam int ST_TO  = 4;
  localparam int ST_PD  = 3;
  localparam logic [7:0] ST_SW_MASK = 8'he7;

  // power_control_status field positions
  localparam int PW_POR = 1;
  localparam int PW_BOR = 0;

  // global_irq_enable inside irq_control
  localparam int IRQ_GIE = 7;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h03;
  localparam logic [IDX_W-1:0] IDX_POWER_CONTROL_STATUS   = 8'h8e;
  localparam logic [IDX_W-1:0] IDX_CAUSE  = 8'h30;

  localparam int NSLOT   = 33;
  localparam int S_STAT  = 0;
  localparam int S_POWER_CONTROL_STATUS  = 1;
  localparam int S_FIRST_PORT_PINS = 7;
  localparam int S_IRQC  = 9;
  localparam int S_PIR   = 10;
  localparam int S_FIRST_PORT_DIRECTION = 19;
  localparam int S_PR2   = 25;
  localparam int S_UIR   = 26;

  // slot order: status, power_control_status, w, timer0_count, fsr, result, capture value, first_port_pins,
  // pc_high_latch, irq_control, pir, pie, timer2_count, timer2_control, txdata, rxdata, adctl,
  // ccpctl, option, first_port_direction..trisd, fifth_port_direction, transmit_control_status, pr2, usb irq/ie/err/erre,
  // usb software state, usb address, usb endpoint control
  localparam logic [IDX_W-1:0] SLOT_IDX [NSLOT] = '{
    8'h03, 8'h8e, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
    8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23,
    8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
  // value loaded on a reset where the bit is not kept
  localparam logic [7:0] SLOT_RST [NSLOT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h3f, 8'hff, 8'h1f,
    8'hff, 8'h07, 8'h02, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // bits held (or left undefined) on power-on, brown-out, pin and watchdog resets
  localparam logic [7:0] SLOT_KEEP_HARD [NSLOT] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h10, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // bits held on a wake-up
  localparam logic [7:0] SLOT_KEEP_WAKE [NSLOT] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // implemented bits; the rest store nothing and read zero
  localparam logic [7:0] SLOT_IMPL [NSLOT] = '{
    8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h1f, 8'hff, 8'hff,
    8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hfd, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h1f,
    8'hff, 8'hf7, 8'hf7, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h0f};

  // reset and wake kinds, most severe first after none
  typedef enum logic [2:0] {
    RK_NONE,
    RK_POR,
    RK_BOR,
    RK_MASTER_CLEAR_PIN_RUN,
    RK_MASTER_CLEAR_PIN_SLEEP,
    RK_WDT_RST,
    RK_WDT_WAKE,
    RK_INT_WAKE
  } rsl_kind_t;

endpackage

/* File: rsl_cause_prio.sv */
`timescale 1ns/1ns
module rsl_cause_prio (
  input  wire logic              por_evt,
  input  wire logic              bor_evt,
  input  wire logic              master_clear_pin_evt,
  input  wire logic              wdt_evt,
  input  wire logic              int_wake_evt,
  input  wire logic              sleeping,
  output rsl_pkg::rsl_kind_t     kind
);
  import rsl_pkg::*;

  // severity order; a watchdog event while asleep is a wake, not a reset
  always_comb begin
    if (por_evt) begin
      kind = RK_POR;
    end else if (bor_evt) begin
      kind = RK_BOR;
    end else if (master_clear_pin_evt) begin
      kind = sleeping ? RK_MASTER_CLEAR_PIN_SLEEP : RK_MASTER_CLEAR_PIN_RUN;
    end else if (wdt_evt) begin
      kind = sleeping ? RK_WDT_WAKE : RK_WDT_RST;
    end else if (int_wake_evt && sleeping) begin
      kind = RK_INT_WAKE;
    end else begin
      kind = RK_NONE;
    end
  end

endmodule

/* File: rsl_wb_slave.sv */
`timescale 1ns/1ns
module rsl_wb_slave (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [rsl_pkg::ADR_W-1:0]   adr_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic [rsl_pkg::DAT_W-1:0]   dat_i,
  output logic      [rsl_pkg::DAT_W-1:0]   dat_o,
  output logic                             ack_o,
  input  wire logic [7:0]                  rd_byte,
  output logic      [rsl_pkg::IDX_W-1:0]   reg_idx,
  output logic                             wr_stb,
  output logic      [7:0]                  wr_byte
);
  import rsl_pkg::*;

  typedef struct packed {
    logic             ack;
    logic [DAT_W-1:0] dat;
  } rsl_wb_state_t;

  rsl_wb_state_t s;
  rsl_wb_state_t next_s;
  logic          req;

  // word index; the two low address bits are ignored, and sel_i[0] alone gates a write
  assign reg_idx = adr_i[ADR_W-1:2];
  assign req     = cyc_i && stb_i;
  assign wr_byte = dat_i[7:0];
  // write lands on the edge where the master sees ack
  assign wr_stb  = s.ack && req && we_i && sel_i[0];
  assign ack_o   = s.ack;
  assign dat_o   = s.dat;

  // one wait state, then ack for a single cycle
  always_comb begin
    next_s     = s;
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      next_s.dat = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* File: rsl_reset_loader.sv */
`timescale 1ns/1ns
// Functional notes
// RL1: power-on: PC zero, status 0001 1xxx
// RL2: pin reset running: PC zero, clear bank bits
// RL3: pin reset asleep: expiry set, sleep clear
// RL4: watchdog reset: expiry clear, sleep set
// RL5: watchdog wake: PC+1, both flags clear
// RL6: brown-out: PC zero, brownout flag cleared
// RL7: interrupt wake: PC+1, expiry set, sleep clear
// RL8: interrupt wake with global enable: vector 0004h
// RL9: wake keeps irq registers, adds wake flags
// RL10: unimplemented bits always read zero
// RL11: status bit layout with bank and flags
// RL12: power flags held on other resets
// RL13: option and first four port directions ones, wake keeps
// RL14: timer2 period forced ones on every event
// RL15: usb registers cleared on every event
// RL16: irq registers cleared, port-change flag held
// RL17: pc high latch cleared, wake keeps
// RL18: timer2, serial, control registers cleared
// RL19: transmit status loads 0000 -010
// RL20: fifth port direction loads 0000 -111
// RL21: first port pins cleared except bit 4
// RL22: data registers held on every reset
// RL23: poweron flag cleared only by power-on
// RL24: power-on always sets both status flags
// RL25: software writes power flags directly
// RL26: most severe simultaneous cause wins
module rsl_reset_loader #(
  parameter int PC_WIDTH = rsl_pkg::PC_W
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [rsl_pkg::ADR_W-1:0]   adr_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic [rsl_pkg::DAT_W-1:0]   dat_i,
  output logic      [rsl_pkg::DAT_W-1:0]   dat_o,
  output logic                             ack_o,
  input  wire logic                        por_evt,
  input  wire logic                        bor_evt,
  input  wire logic                        master_clear_pin_evt,
  input  wire logic                        wdt_evt,
  input  wire logic                        int_wake_evt,
  input  wire logic                        sleeping,
  input  wire logic [7:0]                  irq_wake_set,
  input  wire logic [7:0]                  pir_wake_set,
  input  wire logic [PC_WIDTH-1:0]         pc_now,
  output logic                             pc_load,
  output logic      [PC_WIDTH-1:0]         pc_value,
  output logic      [7:0]                  core_status,
  output rsl_pkg::rsl_kind_t               last_kind
);
  import rsl_pkg::*;

  typedef struct packed {
    logic [NSLOT-1:0][7:0] regs;
    logic [PC_WIDTH-1:0]   pc;
    logic                  pc_load;
    rsl_kind_t             last;
  } rsl_state_t;

  rsl_state_t          s;
  rsl_state_t          next_s;
  rsl_kind_t           kind;
  logic [IDX_W-1:0]    reg_idx;
  logic                wr_stb;
  logic [7:0]          wr_byte;
  logic [7:0]          rd_byte;
  logic                hit;
  int                  slot;
  logic                is_wake;
  logic                global_irq_enable;

  // severity encoder for simultaneous causes
  rsl_cause_prio u_prio (
    .por_evt      (por_evt),
    .bor_evt      (bor_evt),
    .master_clear_pin_evt     (master_clear_pin_evt),
    .wdt_evt      (wdt_evt),
    .int_wake_evt (int_wake_evt),
    .sleeping     (sleeping),
    .kind         (kind)
  ); // RL26

  // register bus front end
  rsl_wb_slave u_bus (
    .clk     (clk),
    .rst     (rst),
    .cyc_i   (cyc_i),
    .stb_i   (stb_i),
    .we_i    (we_i),
    .adr_i   (adr_i),
    .sel_i   (sel_i),
    .dat_i   (dat_i),
    .dat_o   (dat_o),
    .ack_o   (ack_o),
    .rd_byte (rd_byte),
    .reg_idx (reg_idx),
    .wr_stb  (wr_stb),
    .wr_byte (wr_byte)
  );

  // index to slot; linear search keeps the map in one table
  always_comb begin
    hit  = 1'b0;
    slot = 0;
    for (int i = 0; i < NSLOT; i++) begin
      if (SLOT_IDX[i] == reg_idx) begin
        hit  = 1'b1;
        slot = i;
      end
    end
  end

  // read mux; unmapped indices other than the cause index answer zero rather than hang the bus
  always_comb begin
    if (hit) begin
      rd_byte = s.regs[slot] & SLOT_IMPL[slot]; // RL10
    end else if (reg_idx == IDX_CAUSE) begin
      rd_byte = {5'h00, s.last};
    end else begin
      rd_byte = 8'h00;
    end
  end

  assign is_wake = (kind == RK_WDT_WAKE) || (kind == RK_INT_WAKE);
  // vector choice follows the live enable bit in irq_control
  assign global_irq_enable     = s.regs[S_IRQC][IRQ_GIE];

  // next-state: software write first, then any reset load on top of it
  always_comb begin
    next_s         = s;
    next_s.pc_load = 1'b0;

    // status flags are hardware owned; software reaches bank and arithmetic bits
    if (wr_stb && hit) begin
      if (slot == S_STAT) begin
        next_s.regs[S_STAT] = (s.regs[S_STAT] & ~ST_SW_MASK)
                            | (wr_byte & ST_SW_MASK); // RL11
      end else begin
        next_s.regs[slot] = wr_byte & SLOT_IMPL[slot]; // RL25 RL10
      end
    end

    if (kind != RK_NONE) begin
      next_s.last    = kind;
      next_s.pc_load = 1'b1;

      // table-driven load: held bits kept, others take the reset value
      for (int i = 0; i < NSLOT; i++) begin
        if (is_wake) begin
          next_s.regs[i] = ((next_s.regs[i] & SLOT_KEEP_WAKE[i])
                         | (SLOT_RST[i] & ~SLOT_KEEP_WAKE[i]))
                         & SLOT_IMPL[i]; // RL9 RL14 RL15 RL13
        end else begin
          next_s.regs[i] = ((next_s.regs[i] & SLOT_KEEP_HARD[i])
                         | (SLOT_RST[i] & ~SLOT_KEEP_HARD[i]))
                         & SLOT_IMPL[i]; // RL13 RL16 RL17 RL18 RL19 RL20 RL21 RL22
        end
      end

      // the waking event's own flags survive; set beats a same-cycle clear
      if (kind == RK_INT_WAKE) begin
        next_s.regs[S_IRQC] = next_s.regs[S_IRQC] | irq_wake_set; // RL9
        next_s.regs[S_PIR]  = next_s.regs[S_PIR] | pir_wake_set; // RL9
      end

      // program counter target
      if (is_wake) begin
        if (kind == RK_INT_WAKE && global_irq_enable) begin
          next_s.pc = PC_WIDTH'(PC_VECTOR); // RL8
        end else begin
          // wraps at the top of program space, as the core's own counter does
          next_s.pc = PC_WIDTH'(pc_now + PC_WIDTH'(PC_STEP)); // RL5 RL7
        end
      end else begin
        next_s.pc = PC_WIDTH'(PC_RESET); // RL1 RL2 RL3 RL4 RL6
      end

      // bank bits clear on every non-wake reset
      if (!is_wake) begin
        next_s.regs[S_STAT][ST_IRP] = 1'b0; // RL2
        next_s.regs[S_STAT][ST_RP1] = 1'b0;
        next_s.regs[S_STAT][ST_RP0] = 1'b0;
      end

      // cause flags; arithmetic bits are never touched here
      case (kind)
        RK_POR: begin
          next_s.regs[S_STAT][ST_TO]  = 1'b1; // RL1 RL24
          next_s.regs[S_STAT][ST_PD]  = 1'b1;
          next_s.regs[S_POWER_CONTROL_STATUS][PW_POR] = 1'b0; // RL23
        end
        RK_BOR: begin
          next_s.regs[S_POWER_CONTROL_STATUS][PW_BOR] = 1'b0; // RL6
        end
        RK_MASTER_CLEAR_PIN_SLEEP: begin
          next_s.regs[S_STAT][ST_TO] = 1'b1; // RL3
          next_s.regs[S_STAT][ST_PD] = 1'b0;
        end
        RK_WDT_RST: begin
          next_s.regs[S_STAT][ST_TO] = 1'b0; // RL4
          next_s.regs[S_STAT][ST_PD] = 1'b1;
        end
        RK_WDT_WAKE: begin
          next_s.regs[S_STAT][ST_TO] = 1'b0; // RL5
          next_s.regs[S_STAT][ST_PD] = 1'b0;
        end
        RK_INT_WAKE: begin
          next_s.regs[S_STAT][ST_TO] = 1'b1; // RL7
          next_s.regs[S_STAT][ST_PD] = 1'b0;
        end
        default: begin
          // pin reset while running leaves both flags as they were
          next_s.regs[S_STAT] = next_s.regs[S_STAT]; // RL2 RL12
        end
      endcase
    end
  end

  // async reset clears the whole state to zero; the power-on load itself needs por_evt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pc_load     = s.pc_load;
  assign pc_value    = s.pc;
  assign core_status = s.regs[S_STAT];
  assign last_kind   = s.last;

  // ---- checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic hard_kind;
  assign hard_kind = (kind != RK_NONE) && !is_wake;

  a_pc_hard_zero: assert property (hard_kind |=> pc_load && pc_value == PC_RESET) // RL1
    else $error("pc not zero after reset");

  a_pc_irq_vector: assert property (
    (kind == RK_INT_WAKE) && global_irq_enable |=> pc_value == PC_VECTOR) // RL8
    else $error("interrupt wake did not vector");

  a_pc_wake_step: assert property (
    (kind == RK_WDT_WAKE) |=> pc_value == PC_WIDTH'($past(pc_now) + PC_STEP)) // RL5
    else $error("watchdog wake pc not next");

  a_por_flags: assert property (
    (kind == RK_POR) |=> core_status[ST_TO:ST_PD] == 2'b11
                       && core_status[ST_IRP:ST_RP0] == 3'b000) // RL24
    else $error("power-on status flags wrong");

  a_master_clear_pin_sleep_flags: assert property (
    (kind == RK_MASTER_CLEAR_PIN_SLEEP) |=> core_status[ST_TO:ST_PD] == 2'b10) // RL3
    else $error("pin reset in sleep flags wrong");

  a_wdt_reset_flags: assert property (
    (kind == RK_WDT_RST) |=> core_status[ST_TO:ST_PD] == 2'b01) // RL4
    else $error("watchdog reset flags wrong");

  a_int_wake_flags: assert property (
    (kind == RK_INT_WAKE) |=> core_status[ST_TO:ST_PD] == 2'b10
                            && last_kind == RK_INT_WAKE) // RL7
    else $error("interrupt wake flags wrong");

  a_bor_power_control_status_flag: assert property (
    (kind == RK_BOR) |=> !s.regs[S_POWER_CONTROL_STATUS][PW_BOR]
                       && s.regs[S_POWER_CONTROL_STATUS][PW_POR] == $past(s.regs[S_POWER_CONTROL_STATUS][PW_POR])) // RL6
    else $error("brown-out power flags wrong");

  a_power_control_status_held: assert property (
    (kind inside {RK_MASTER_CLEAR_PIN_RUN, RK_MASTER_CLEAR_PIN_SLEEP, RK_WDT_RST, RK_WDT_WAKE, RK_INT_WAKE})
    |=> s.regs[S_POWER_CONTROL_STATUS] == $past(s.regs[S_POWER_CONTROL_STATUS])) // RL12
    else $error("power flags changed on other reset");

  a_period_ones: assert property ((kind != RK_NONE) |=> s.regs[S_PR2] == 8'hff) // RL14
    else $error("timer2 period not ones");

  a_usb_cleared: assert property ((kind != RK_NONE) |=> s.regs[S_UIR] == 8'h00) // RL15
    else $error("usb flags not cleared");

  a_wake_keeps_dir: assert property (
    is_wake && !wr_stb |=> s.regs[S_FIRST_PORT_DIRECTION] == $past(s.regs[S_FIRST_PORT_DIRECTION])) // RL13
    else $error("direction changed on wake");

  // power-on beats any cause that arrives with it
  a_por_priority: assert property (por_evt |=> pc_load && last_kind == RK_POR) // RL26
    else $error("power-on lost priority");

  c_por_seen: cover property (kind == RK_POR ##1 pc_load);
  c_irq_vector: cover property ((kind == RK_INT_WAKE) && global_irq_enable);
  c_wdt_wake: cover property (kind == RK_WDT_WAKE);
  c_bus_write: cover property (wr_stb && hit);

endmodule

/* File: rsl_core_model.sv */
`timescale 1ns/1ns
// behavioural core: steps the pc, parks it in sleep, jumps on a load
module rsl_core_model (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    pc_load,
  input  wire logic [rsl_pkg::PC_W-1:0] pc_value,
  input  wire logic                    sleep_req,
  output logic      [rsl_pkg::PC_W-1:0] pc_now,
  output logic                         sleeping
);
  import rsl_pkg::*;

  // pc frozen while asleep so a wake target is predictable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_now   <= PC_RESET;
      sleeping <= 1'b0;
    end else if (pc_load) begin
      pc_now   <= pc_value; // any reset or wake leaves sleep
      sleeping <= 1'b0;
    end else begin
      if (!sleeping) pc_now <= pc_now + PC_STEP;
      if (sleep_req) sleeping <= 1'b1;
    end
  end
endmodule

/* File: rsl_reset_loader_tb.sv */
`timescale 1ns/1ns
module rsl_reset_loader_tb;
  import rsl_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] dat_w = '0;
  logic [DAT_W-1:0] dat_o;
  logic             ack_o, pc_load, sleeping;
  logic             por = 1'b0, bor = 1'b0, master_clear_pin = 1'b0, wdt = 1'b0, intw = 1'b0;
  logic             sleep_req = 1'b0;
  logic [7:0]       irq_set = 8'h00, pir_set = 8'h00, core_status, rv, rw;
  logic [PC_W-1:0]  pc_now, pc_value;
  rsl_kind_t        last_kind;
  logic [31:0]      exp_rd [$];
  logic [15:0]      exp_ev [$];
  int               n_errors = 0, checks_done = 0, cycles = 0, seed = 50;
  logic [7:0]       ti [8] = '{8'h8e, 8'h20, 8'h21, 8'h22, 8'h25, 8'h26, 8'h27, 8'h15};
  logic [7:0]       tv [8] = '{8'h00, 8'hff, 8'h3f, 8'hff, 8'h07, 8'h02, 8'hff, 8'h00};

  always #25 clk = ~clk;

  rsl_reset_loader dut_u (
    .clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o),
    .por_evt(por), .bor_evt(bor), .master_clear_pin_evt(master_clear_pin), .wdt_evt(wdt),
    .int_wake_evt(intw), .sleeping(sleeping), .irq_wake_set(irq_set),
    .pir_wake_set(pir_set), .pc_now(pc_now), .pc_load(pc_load),
    .pc_value(pc_value), .core_status(core_status), .last_kind(last_kind));

  rsl_core_model core_u (
    .clk(clk), .rst(rst), .pc_load(pc_load), .pc_value(pc_value),
    .sleep_req(sleep_req), .pc_now(pc_now), .sleeping(sleeping));

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // watcher: each result is matched with the oldest pending note
  always @(posedge clk) begin
    if (ack_o === 1'b1 && we === 1'b0)
      chk(dat_o, exp_rd.size() ? exp_rd.pop_front() : 32'hxxxx_xxxx);
    if (pc_load === 1'b1)
      chk({16'h0, last_kind, pc_value}, {16'h0, exp_ev.size() ? exp_ev.pop_front() : 16'hxxxx});
  end

  // hang guard; a whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end

  // classic wishbone single cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [7:0] e);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= {24'h0, d};
    if (!w) exp_rd.push_back({24'h0, e});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n == 20) n_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // status reads also check the core_status output, which must agree
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, e);
    if (idx == IDX_STATUS) chk({24'h0, core_status}, {24'h0, e});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 8'h00);
  endtask

  // one-cycle cause pulse {por,bor,master_clear_pin,wdt,int}; a load notes the target
  task automatic ev(input logic [4:0] e, input rsl_kind_t k, input logic [PC_W-1:0] p,
                    input logic load);
    @(posedge clk);
    {por, bor, master_clear_pin, wdt, intw} <= e;
    if (load) exp_ev.push_back({k, p});
    @(posedge clk);
    {por, bor, master_clear_pin, wdt, intw} <= 5'h00;
    repeat (2) @(posedge clk);
  endtask

  // put the core to sleep; pc stands still afterwards
  task automatic nap();
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // main sequence
  initial begin
    rv = 8'($random(seed));
    rw = 8'($random(seed)) & 8'h7f;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    ev(5'b10000, RK_POR, PC_RESET, 1'b1);
    rd(IDX_STATUS, 8'h18);
    for (int i = 0; i < 8; i++) rd(ti[i], tv[i]);
    wr(IDX_POWER_CONTROL_STATUS, 8'h03);
    wr(IDX_STATUS, 8'hff);
    wr(8'h10, rv);
    wr(8'h21, 8'h00);
    wr(8'h27, 8'h12);
    wr(8'h28, 8'hff);
    wr(8'h17, 8'h01);
    wr(8'h15, 8'hff);
    wr(8'h16, 8'hff);
    rd(IDX_POWER_CONTROL_STATUS, 8'h03);
    rd(8'h28, 8'h3f);
    rd(8'h15, 8'h3f);
    rd(8'h16, 8'h1f);
    rd(8'h27, 8'h12);
    // pin reset while running
    ev(5'b00100, RK_MASTER_CLEAR_PIN_RUN, PC_RESET, 1'b1);
    rd(IDX_STATUS, 8'h1f);
    rd(IDX_POWER_CONTROL_STATUS, 8'h03);
    rd(8'h10, rv);
    rd(8'h21, 8'h3f);
    rd(8'h27, 8'hff);
    rd(8'h28, 8'h00);
    rd(8'h17, 8'h01);
    rd(8'h16, 8'h00);
    rd(8'h15, 8'h10);
    // watchdog reset, then flags must resist a software write
    ev(5'b00010, RK_WDT_RST, PC_RESET, 1'b1);
    rd(IDX_STATUS, 8'h0f);
    wr(IDX_STATUS, 8'he7);
    rd(IDX_STATUS, 8'hef);
    wr(8'h21, 8'h00);
    wr(8'h16, 8'h05);
    wr(8'h17, 8'h00);
    wr(8'h28, 8'h3f);
    wr(8'h27, 8'h12);
    // watchdog wake from sleep
    nap();
    ev(5'b00010, RK_WDT_WAKE, pc_now + PC_STEP, 1'b1);
    rd(IDX_STATUS, 8'he7);
    rd(8'h21, 8'h00);
    rd(8'h16, 8'h05);
    rd(8'h28, 8'h00);
    rd(8'h27, 8'hff);
    rd(8'h10, rv);
    // interrupt wake with global enable clear
    irq_set <= rw;
    pir_set <= 8'h01;
    nap();
    ev(5'b00001, RK_INT_WAKE, pc_now + PC_STEP, 1'b1);
    rd(IDX_STATUS, 8'hf7);
    rd(8'h17, rw);
    rd(8'h18, 8'h01);
    // interrupt wake while awake is ignored
    ev(5'b00001, RK_NONE, PC_RESET, 1'b0);
    rd(IDX_STATUS, 8'hf7);
    // interrupt wake with global enable set goes to the vector
    wr(8'h17, 8'h80);
    nap();
    ev(5'b00001, RK_INT_WAKE, PC_VECTOR, 1'b1);
    rd(8'h17, 8'h80 | rw);
    // pin reset while asleep
    nap();
    ev(5'b00100, RK_MASTER_CLEAR_PIN_SLEEP, PC_RESET, 1'b1);
    rd(IDX_STATUS, 8'h17);
    // brown-out clears only its own flag
    ev(5'b01000, RK_BOR, PC_RESET, 1'b1);
    rd(IDX_POWER_CONTROL_STATUS, 8'h02);
    rd(IDX_STATUS, 8'h17);
    rd(8'h10, rv);
    // power-on and brown-out together: power-on wins
    ev(5'b11000, RK_POR, PC_RESET, 1'b1);
    rd(IDX_POWER_CONTROL_STATUS, 8'h00);
    rd(IDX_STATUS, 8'h1f);
    // unmapped index and unimplemented bits
    rd(8'h3f, 8'h00);
    wr(8'h26, 8'hff);
    rd(8'h26, 8'hf7);
    wr(8'h25, 8'hff);
    rd(8'h25, 8'hf7);
    repeat (3) @(posedge clk);
    if (exp_ev.size() != 0 || exp_rd.size() != 0) n_errors++;
    final_report();
  end
endmodule
